//--- hdl/qdc_pkg.sv
// Purpose: Shared constants and types for the quad converter update control.
// Assumes: AHB-Lite register bus, 32-bit words, one aligned word per register.
// Notes: Frame layout and register offsets are collected here.
package qdc_pkg;

   // Serial frame
   localparam int FRAME_BITS = 32;
   localparam int CODE_BITS = 16;
   localparam int CHANNELS = 4;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic [3:0] spare;
      logic [3:0] cmd;
      logic [3:0] addr;
      logic [15:0] data;
      logic [3:0] feature;
   } qdc_frame_s;

   // Frame commands
   localparam logic [3:0] CMD_WR_IN = 4'h0;
   localparam logic [3:0] CMD_UPD_N = 4'h1;
   localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WR_UPD_N = 4'h3;
   localparam logic [3:0] CMD_CLR_CODE = 4'h5;
   localparam logic [3:0] CMD_REF = 4'h8;
   localparam logic [3:0] ADDR_ALL = 4'hf;

   // Clear-code selection and the codes it yields
   localparam logic [1:0] CLR_ZERO = 2'h0;
   localparam logic [1:0] CLR_MID = 2'h1;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_FRAMES = 8'h08;
   localparam logic [7:0] OFS_ABORTS = 8'h0c;
   localparam logic [7:0] OFS_DAC0 = 8'h10;
   localparam logic [7:0] OFS_IN0 = 8'h20;

   // Register fields
   localparam int CTRL_SOFT_LOAD = 0;
   localparam int CTRL_SDO_EN = 1;
   localparam logic CTRL_SDO_EN_RST = 1'b1;

   // Pin synchroniser lanes
   localparam int PIN_SCLK = 0;
   localparam int PIN_SYNC_N = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_LOAD_N = 3;
   localparam int PIN_CLEAR_N = 4;
   localparam int PIN_POR = 5;
   localparam int PIN_COUNT = 6;
   localparam logic [5:0] PIN_RST = 6'h3b;

   // AHB-Lite
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- hdl/qdc_top.sv
// Purpose: Serial update control for a quad 16-bit voltage-output converter.
// Assumes: Serial pins are asynchronous, oversampled by I_CLK (200 MHz).
// Notes: Registers over AHB-Lite, zero wait states, always OKAY.
//
// Overview of operation
// - Frame sync low opens a frame; 32 bits taken on falling serial-clock edges.
// - Frame sync rising before the 32nd edge aborts; no channel or control register changes, only the abort count rises.
// - Shift register MSB appears on serial out, changing on rising clock edges.
// - Four channels, each with its own input and DAC register.
// - Load strobe falling edge copies every pending input register to its DAC.
// - Load strobe held low permanently still works correctly.
// - Clear acts on its falling edge, not on its level.
// - While clear is low, load strobes, soft load and update-all are ignored; per-channel update commands still transfer.
// - Clear loads input and DAC registers with zero, mid or full scale.
// - Clear-code setting resets to zero scale.
// - Power-up loads DAC registers with zero or midscale from the strap pin.
// - Reference pin defaults to external input; internal reference off.
// - Internal reference is enabled only by a serial command frame.
// - DAC registers hold 16-bit straight binary codes.
`timescale 1ns/1ps

module qdc_top
   import qdc_pkg::*;
#(
   parameter int NCH = CHANNELS,
   parameter int CW = CODE_BITS
) (
   // Clock and reset
   input wire logic I_CLK,
   input wire logic I_RST,
   // Serial link pins
   input wire logic I_SCLK,
   input wire logic I_SYNC_N,
   input wire logic I_DIN,
   output logic O_SERIAL_OUT,
   // Converter control pins
   input wire logic I_LOAD_STROBE_N,
   input wire logic I_ASYNC_CLEAR_N,
   input wire logic I_POR_SEL,
   // Converter side
   output logic [NCH-1:0][CW-1:0] O_DAC_CODE,
   output logic O_INT_REF_EN,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [CW-1:0] clear_value(input logic [1:0] sel);
      logic [CW-1:0] v;
      v = CODE_FULL;
      if (sel == CLR_ZERO) begin
         v = CODE_ZERO;
      end else if (sel == CLR_MID) begin
         v = CODE_MID;
      end
      return v;
   endfunction

   function automatic logic chan_hit(input logic [3:0] addr, input int ch);
      return (addr == ADDR_ALL) || (addr == 4'(ch));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a lane changes once stages two and three agree

   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_s1;
   logic [PIN_COUNT-1:0] pin_s2;
   logic [PIN_COUNT-1:0] pin_s3;
   logic [PIN_COUNT-1:0] pin_f;
   logic [PIN_COUNT-1:0] pin_fq;
   logic [PIN_COUNT-1:0] next_pin_f;

   assign pin_raw = {I_POR_SEL, I_ASYNC_CLEAR_N, I_LOAD_STROBE_N, I_DIN, I_SYNC_N, I_SCLK};
   assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         pin_s1 <= PIN_RST;
         pin_s2 <= PIN_RST;
         pin_s3 <= PIN_RST;
         pin_f <= PIN_RST;
         pin_fq <= PIN_RST;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= next_pin_f;
         pin_fq <= pin_f;
      end
   end

   wire sclk_fall = pin_fq[PIN_SCLK] & ~pin_f[PIN_SCLK];
   wire sclk_rise = ~pin_fq[PIN_SCLK] & pin_f[PIN_SCLK];
   wire sync_fall = pin_fq[PIN_SYNC_N] & ~pin_f[PIN_SYNC_N];
   wire sync_rise = ~pin_fq[PIN_SYNC_N] & pin_f[PIN_SYNC_N];
   wire din_bit = pin_f[PIN_DIN];
   wire load_fall = pin_fq[PIN_LOAD_N] & ~pin_f[PIN_LOAD_N];
   wire load_low = ~pin_f[PIN_LOAD_N];
   wire clear_fall = pin_fq[PIN_CLEAR_N] & ~pin_f[PIN_CLEAR_N];
   wire clear_low = ~pin_f[PIN_CLEAR_N];

   ////////////////////////////////////////////////////////////////////////////
   // Frame capture

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_SHIFT,
      FR_FULL
   } qdc_frame_e;

   qdc_frame_e fr_state;
   logic [FRAME_BITS-1:0] shreg;
   logic [5:0] bit_cnt;
   logic frame_done;
   logic frame_abort;
   qdc_frame_s frame;

   wire last_bit = (bit_cnt == 6'(FRAME_BITS - 1));
   wire take_bit = (fr_state == FR_SHIFT) && sclk_fall;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         fr_state <= FR_IDLE;
         bit_cnt <= 6'h00;
         frame_done <= 1'b0;
         frame_abort <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         frame_abort <= 1'b0;
         case (fr_state)
            FR_IDLE: begin
               if (sync_fall) begin
                  fr_state <= FR_SHIFT;
                  bit_cnt <= 6'h00;
               end
            end
            FR_SHIFT: begin
               if (sync_rise) begin
                  fr_state <= FR_IDLE;
                  frame_abort <= 1'b1;
               end else if (sclk_fall) begin
                  bit_cnt <= bit_cnt + 6'h01;
                  if (last_bit) begin
                     fr_state <= FR_FULL;
                     frame_done <= 1'b1;
                  end
               end
            end
            FR_FULL: begin
               // Extra edges after the 32nd are ignored until sync returns high
               if (sync_rise) begin
                  fr_state <= FR_IDLE;
               end
            end
            default: begin
               fr_state <= FR_IDLE;
            end
         endcase
      end
   end

   // Shift register runs only inside a frame
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         shreg <= '0;
      end else if (take_bit) begin
         shreg <= {shreg[FRAME_BITS-2:0], din_bit};
      end
   end

   assign frame = qdc_frame_s'(shreg);

   ////////////////////////////////////////////////////////////////////////////
   // Serial output

   logic sdo_en;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_SERIAL_OUT <= 1'b0;
      end else if (!sdo_en) begin
         O_SERIAL_OUT <= 1'b0;
      end else if (sclk_rise) begin
         O_SERIAL_OUT <= shreg[FRAME_BITS-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   wire cmd_write = frame_done && ((frame.cmd == CMD_WR_IN) || (frame.cmd == CMD_WR_UPD_ALL)
                                   || (frame.cmd == CMD_WR_UPD_N));
   wire cmd_upd_n = frame_done && (frame.cmd == CMD_UPD_N);
   wire cmd_wr_upd = frame_done && (frame.cmd == CMD_WR_UPD_N);
   wire cmd_all = frame_done && (frame.cmd == CMD_WR_UPD_ALL);
   // Tied-low strobe: a plain write goes straight through, unless clear holds
   wire direct_wr = frame_done && (frame.cmd == CMD_WR_IN) && load_low && !clear_low;
   logic soft_load;
   // Transfer of pending channels; clear low blocks every strobe
   wire xfer_all = (load_fall || soft_load || cmd_all) && !clear_low;

   logic [1:0] clr_code;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         clr_code <= CLR_ZERO;
         O_INT_REF_EN <= 1'b0;
      end else if (frame_done) begin
         if (frame.cmd == CMD_CLR_CODE) begin
            clr_code <= frame.data[1:0];
         end
         if (frame.cmd == CMD_REF) begin
            O_INT_REF_EN <= frame.data[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-up strap: caught once the synchroniser has settled after release

   logic [2:0] por_cnt;
   logic por_load;
   wire por_wait = (por_cnt != 3'(SYNC_STAGES + 1));

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         por_cnt <= 3'h0;
         por_load <= 1'b0;
      end else begin
         por_load <= 1'b0;
         if (por_wait) begin
            por_cnt <= por_cnt + 3'h1;
            por_load <= (por_cnt == 3'(SYNC_STAGES));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel registers

   logic [CW-1:0] in_reg [NCH];
   logic [NCH-1:0] pend;
   wire [CW-1:0] clear_code = clear_value(clr_code);
   wire [CW-1:0] por_code = pin_f[PIN_POR] ? CODE_MID : CODE_ZERO;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire hit = chan_hit(frame.addr, c);
      wire wr_in = cmd_write && hit;
      wire direct = hit && (cmd_upd_n || cmd_wr_upd || direct_wr);
      wire [CW-1:0] new_in = wr_in ? frame.data : in_reg[c];

      always_ff @(posedge I_CLK) begin
         if (I_RST) begin
            in_reg[c] <= CODE_ZERO;
            O_DAC_CODE[c] <= CODE_ZERO;
            pend[c] <= 1'b0;
         end else if (clear_fall) begin
            in_reg[c] <= clear_code;
            O_DAC_CODE[c] <= clear_code;
            pend[c] <= 1'b0;
         end else begin
            in_reg[c] <= new_in;
            if (por_load) begin
               O_DAC_CODE[c] <= por_code;
            end else if (direct) begin
               O_DAC_CODE[c] <= new_in;
            end else if (xfer_all && (pend[c] || wr_in)) begin
               O_DAC_CODE[c] <= new_in;
            end
            if (direct || xfer_all) begin
               pend[c] <= 1'b0;
            end else if (wr_in) begin
               pend[c] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Statistics

   logic [15:0] frames_cnt;
   logic [15:0] aborts_cnt;

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         frames_cnt <= 16'h0000;
         aborts_cnt <= 16'h0000;
      end else begin
         if (frame_done) begin
            frames_cnt <= frames_cnt + 16'h0001;
         end
         if (frame_abort) begin
            aborts_cnt <= aborts_cnt + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, read data registered in the data phase

   logic dp_wr;
   logic [7:0] dp_addr;

   wire ap_valid = HSEL && HTRANS[1] && HREADY;
   wire [7:0] ap_addr = {HADDR[7:2], 2'b00};
   wire ap_in_dac = (ap_addr >= OFS_DAC0) && (ap_addr < OFS_DAC0 + 8'(4 * NCH));
   wire ap_in_in = (ap_addr >= OFS_IN0) && (ap_addr < OFS_IN0 + 8'(4 * NCH));
   wire [7:0] dac_ofs = ap_addr - OFS_DAC0;
   wire [7:0] in_ofs = ap_addr - OFS_IN0;
   wire [1:0] dac_idx = dac_ofs[3:2];
   wire [1:0] in_idx = in_ofs[3:2];
   wire [31:0] status_word = {20'h00000, pend, 3'h0, fr_state != FR_IDLE, clear_low,
                              clr_code, O_INT_REF_EN};
   wire [31:0] rd_mux =
      (ap_addr == OFS_CTRL) ? {30'h0, sdo_en, 1'b0} :
      (ap_addr == OFS_STATUS) ? status_word :
      (ap_addr == OFS_FRAMES) ? {16'h0000, frames_cnt} :
      (ap_addr == OFS_ABORTS) ? {16'h0000, aborts_cnt} :
      ap_in_dac ? {16'h0000, O_DAC_CODE[dac_idx]} :
      ap_in_in ? {16'h0000, in_reg[in_idx]} : 32'h00000000;
   wire ctrl_wr = dp_wr && (dp_addr == OFS_CTRL);

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         HRDATA <= 32'h00000000;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         dp_wr <= ap_valid && HWRITE;
         dp_addr <= ap_addr;
         HRDATA <= (ap_valid && !HWRITE) ? rd_mux : 32'h00000000;
      end
   end

   // Soft load is a one-cycle pulse, so software needs no second write to drop it
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         sdo_en <= CTRL_SDO_EN_RST;
         soft_load <= 1'b0;
      end else begin
         soft_load <= ctrl_wr && HWDATA[CTRL_SOFT_LOAD];
         if (ctrl_wr) begin
            sdo_en <= HWDATA[CTRL_SDO_EN];
         end
      end
   end

endmodule

//--- bench/qdc_top_asserts.sv
// Purpose: Port checks for the quad converter update control.
// Assumes: Bound to qdc_top; the bench leaves the bus idle in quiet spans.
// Notes: Quiet spans are eight cycles, beyond the pin synchroniser delay.
`timescale 1ns/1ps
module qdc_top_asserts
   import qdc_pkg::*;
#(
   parameter int NCH = CHANNELS,
   parameter int CW = CODE_BITS
) (
   // Clock, reset and inputs
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_SCLK,
   input wire logic I_SYNC_N,
   input wire logic I_LOAD_STROBE_N,
   input wire logic I_ASYNC_CLEAR_N,
   input wire logic I_POR_SEL,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   // Outputs
   input wire logic O_SERIAL_OUT,
   input wire logic [NCH-1:0][CW-1:0] O_DAC_CODE,
   input wire logic O_INT_REF_EN,
   input wire logic HREADYOUT,
   input wire logic HRESP
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   wire bus_idle = !(HSEL && HTRANS[1]);
   wire same = (O_DAC_CODE == {NCH{O_DAC_CODE[0]}});
   wire [CW-1:0] c0 = O_DAC_CODE[0];
   wire clr_ok = same && (c0 == CODE_ZERO || c0 == CODE_MID || c0 == CODE_FULL);
   wire por_ok = (O_DAC_CODE == {NCH{I_POR_SEL ? CODE_MID : CODE_ZERO}});
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_quiet;
      (I_SYNC_N && I_LOAD_STROBE_N && I_ASYNC_CLEAR_N && bus_idle) [*8];
   endsequence
   sequence s_clr_held;
      (!I_ASYNC_CLEAR_N && I_SYNC_N && bus_idle) [*8];
   endsequence
   sequence s_clr_fall;
      $fell(I_ASYNC_CLEAR_N) ##1 (!I_ASYNC_CLEAR_N) [*2];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   AST_DAC_QUIET: assert property (s_quiet |=> $stable(O_DAC_CODE))
      else $error("DAC code moved with no cause");
   AST_CLR_BLOCKS: assert property (s_clr_held |=> $stable(O_DAC_CODE))
      else $error("DAC code moved while clear held low");
   AST_CLR_CODE: assert property (s_clr_fall |-> ##[1:8] clr_ok)
      else $error("Clear did not load a clear code");
   AST_POR: assert property ($fell(I_RST) |-> ##[3:7] por_ok)
      else $error("Power-up code wrong");
   AST_REF_RST: assert property ($fell(I_RST) |-> (!O_INT_REF_EN) [*3])
      else $error("Internal reference on after reset");
   AST_REF_QUIET: assert property (I_SYNC_N [*8] |=> $stable(O_INT_REF_EN))
      else $error("Reference enable moved outside frames");
   AST_SDO_HOLD: assert property ((!I_SCLK) [*6] |=> $stable(O_SERIAL_OUT))
      else $error("Serial out moved while serial clock low");
   AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
      else $error("Bus not ready or not okay");
endmodule

bind qdc_top qdc_top_asserts #(.NCH(NCH), .CW(CW)) chk_u (.I_CLK(I_CLK), .I_RST(I_RST),
   .I_SCLK(I_SCLK), .I_SYNC_N(I_SYNC_N), .I_LOAD_STROBE_N(I_LOAD_STROBE_N),
   .I_ASYNC_CLEAR_N(I_ASYNC_CLEAR_N), .I_POR_SEL(I_POR_SEL), .HSEL(HSEL),
   .HTRANS(HTRANS), .O_SERIAL_OUT(O_SERIAL_OUT), .O_DAC_CODE(O_DAC_CODE),
   .O_INT_REF_EN(O_INT_REF_EN), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

//--- bench/qdc_host.sv
// Purpose: Host serial port model driving frames into the converter.
// Assumes: Serial clock of 64 ns, standing high between frames.
// Notes: Readback is shifted in on every falling serial clock edge.
`timescale 1ns/1ps
module qdc_host (
   // Link pins
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_din,
   // Readback
   input wire logic i_sdo,
   output logic [31:0] o_rx
);
   initial begin
      o_sclk = 1'b1;
      o_sync_n = 1'b1;
      o_din = 1'b0;
      o_rx = 32'h0;
   end
   // Data set during the high half so it is settled at the fall
   // Half-ns offset keeps every pin change off the rising edges of the 5 ns clock
   task automatic send(input logic [31:0] w, input int n);
      #0.5;
      o_sync_n = 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         o_din = w[i];
         #32;
         o_sclk = 1'b0;
         o_rx = {o_rx[30:0], i_sdo};
         #32;
         o_sclk = 1'b1;
      end
      o_din = ~o_din;
      o_sync_n = 1'b1;
      #160;
   endtask
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the quad converter update control.
// Assumes: Reads are scored by a monitor against a queue of expectations.
// Notes: Inputs tie off only HSIZE; HREADY loops back from HREADYOUT.
`timescale 1ns/1ps
module tb
   import qdc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ld_n = 1'b1;
   logic clr_n = 1'b1;
   logic por = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   wire sclk, sync_n, din, serial_out, ref_en, hready, hresp;
   wire [31:0] hrdata, rx;
   wire [3:0][15:0] dac;
   int fails = 0;
   int tests_run = 0;
   int nfr = 0;
   logic [63:0] q[$];
   logic [63:0] m;
   logic rd_dp = 1'b0;
   logic [15:0] dm[4], im[4], v, c;
   logic [31:0] last, w;
   always #2.5 clk = ~clk;
   qdc_top dut_u (.I_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_SYNC_N(sync_n), .I_DIN(din),
      .O_SERIAL_OUT(serial_out), .I_LOAD_STROBE_N(ld_n), .I_ASYNC_CLEAR_N(clr_n), .I_POR_SEL(por),
      .O_DAC_CODE(dac), .O_INT_REF_EN(ref_en), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp));
   qdc_host host_u (.o_sclk(sclk), .o_sync_n(sync_n), .o_din(din), .i_sdo(serial_out), .o_rx(rx));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(posedge clk) begin
      if (rd_dp && hready) begin
         m = q.pop_front();
         cmp(hrdata & m[63:32], m[31:0]);
      end
      rd_dp <= hsel && htrans[1] && !hwrite && hready;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] mk = 32'hffffffff);
      if (!wr) q.push_back({mk, d});
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic chk(input bit ins = 1'b1);
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, OFS_DAC0 + 8'(4 * i), {16'h0, dm[i]});
         if (ins) xfer(1'b0, OFS_IN0 + 8'(4 * i), {16'h0, im[i]});
      end
   endtask
   task automatic frame(input logic [3:0] cm, input logic [3:0] a, input logic [15:0] d,
         input int n = 32);
      last = {4'h0, cm, a, d, 4'h0};
      host_u.send(last, n);
      if (n == FRAME_BITS) nfr++;
      repeat (8) @(posedge clk);
   endtask
   task automatic pulse();
      @(posedge clk);
      ld_n <= 1'b0;
      repeat (4) @(posedge clk);
      ld_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic reset_dut(input logic p);
      @(posedge clk);
      rst <= 1'b1;
      por <= p;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic test_done();
      repeat (4) @(posedge clk);
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      test_done();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(34778));
      reset_dut(1'b0);
      dm = '{default: CODE_ZERO};
      im = '{default: CODE_ZERO};
      xfer(1'b0, OFS_CTRL, 32'h2, 32'h3);
      xfer(1'b0, OFS_STATUS, 32'h0, 32'h7);
      xfer(1'b0, 8'h40, 32'h0);
      chk();
      $display("done: reset values");
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         frame(CMD_WR_IN, 4'(i), v);
         im[i] = v;
      end
      chk();
      pulse();
      dm = im;
      chk();
      frame(CMD_WR_UPD_N, 4'h0, 16'h1234, 20);
      frame(CMD_WR_UPD_N, 4'h0, 16'h4321, 31);
      chk();
      xfer(1'b0, OFS_ABORTS, 32'h2, 32'hffff);
      $display("done: load and abort");
      v = 16'($urandom);
      frame(CMD_WR_UPD_N, 4'h1, v);
      im[1] = v;
      dm[1] = v;
      v = 16'($urandom);
      frame(CMD_WR_IN, 4'h2, v);
      im[2] = v;
      frame(CMD_UPD_N, 4'h2, 16'h0);
      dm[2] = v;
      v = 16'($urandom);
      frame(CMD_WR_IN, 4'h3, v);
      im[3] = v;
      v = 16'($urandom);
      frame(CMD_WR_UPD_ALL, 4'h0, v);
      im[0] = v;
      dm[0] = v;
      dm[3] = im[3];
      chk();
      cmp({31'h0, ref_en}, 32'h0);
      frame(CMD_REF, 4'h0, 16'h0001);
      cmp({31'h0, ref_en}, 32'h1);
      xfer(1'b0, OFS_STATUS, 32'h1, 32'h1);
      @(posedge clk);
      ld_n <= 1'b0;
      v = 16'($urandom);
      frame(CMD_WR_IN, 4'h3, v);
      im[3] = v;
      dm[3] = v;
      chk();
      @(posedge clk);
      ld_n <= 1'b1;
      $display("done: commands");
      for (int k = 0; k < 3; k++) begin
         c = (k == 0) ? CODE_ZERO : (k == 1) ? CODE_MID : CODE_FULL;
         if (k > 0) frame(CMD_CLR_CODE, 4'h0, 16'(k));
         @(posedge clk);
         clr_n <= 1'b0;
         repeat (10) @(posedge clk);
         im = '{default: c};
         dm = '{default: c};
         v = 16'($urandom);
         frame(CMD_WR_IN, 4'h0, v);
         im[0] = v;
         pulse();
         chk();
         xfer(1'b0, OFS_STATUS, 32'h108, 32'hf08);
         @(posedge clk);
         clr_n <= 1'b1;
         repeat (8) @(posedge clk);
      end
      $display("done: clear codes");
      frame(CMD_WR_IN, 4'h1, 16'($urandom));
      w = last;
      im[1] = w[19:4];
      frame(CMD_WR_IN, 4'h1, 16'($urandom));
      im[1] = last[19:4];
      cmp({1'b0, rx[30:0]}, {1'b0, w[30:0]});
      xfer(1'b1, OFS_CTRL, 32'h3);
      dm[0] = im[0];
      dm[1] = im[1];
      chk();
      // Unknown command with a set top bit: ignored, but leaves serial out high
      host_u.send(32'hff000000, FRAME_BITS);
      nfr++;
      repeat (8) @(posedge clk);
      cmp({31'h0, serial_out}, 32'h1);
      xfer(1'b1, OFS_CTRL, 32'h0);
      xfer(1'b0, OFS_CTRL, 32'h0, 32'h3);
      cmp({31'h0, serial_out}, 32'h0);
      xfer(1'b0, OFS_FRAMES, 32'(nfr), 32'hffff);
      $display("done: readback and soft load");
      reset_dut(1'b1);
      dm = '{default: CODE_MID};
      chk(1'b0);
      xfer(1'b0, OFS_STATUS, 32'h0, 32'h7);
      $display("done: second reset");
      test_done();
   end
endmodule
